//--- sid_filter.sv
`timescale 1ns/1ps
`default_nettype none
module sid_filter #(
    parameter int CNT_W = 6
) (
    input wire logic clock_i, // System clock
    input wire logic rst_b_i, // Sync reset, active low
    input wire logic tick_i, // One-millisecond enable
    input wire logic raw_i, // Synchronised raw level
    input wire logic [CNT_W-1:0] limit_i, // Hold time in ticks
    output logic state_o // Debounced level
);
    logic state_q;
    logic [CNT_W-1:0] cnt_q;
    wire differs = raw_i != state_q;
    wire done = (cnt_q + 1'b1) >= limit_i;
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_q <= 1'b0;
            cnt_q <= '0;
        end else if (tick_i) begin
            if (!differs) begin
                cnt_q <= '0;
            end else if (limit_i == '0 || done) begin
                state_q <= raw_i;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
    assign state_o = state_q;
endmodule
`default_nettype wire

//--- sid_pkg.sv
package sid_pkg;
    localparam int SID_CLK_HZ = 100000000;
    localparam int SID_TICK_MS = 1;
    localparam int SID_CYC_PER_MS = SID_CLK_HZ / 1000 * SID_TICK_MS;
    localparam int SID_NUM_INPUTS = 16;
    localparam int SID_NUM_SENSE = 7;
    localparam int SID_SENSE_LSB = 8;
    localparam int SID_STEP_MS = 4;
    localparam int SID_WORD_MS = 4;
    localparam int SID_SET_W = 4;
    localparam int SID_SET_MAX = 8;
    localparam logic [3:0] SID_SET_DEFAULT = 4'h4;
    localparam int SID_CNT_W = 6;
    localparam logic [15:0] SID_WORD_RESET = 16'h0000;
endpackage

//--- sid_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sid_properties (
    input wire logic clock_i, // Clock
    input wire logic rst_b_i, // Reset
    input wire logic set_wr_i, // Write
    input wire logic [3:0] set_val_i, // Value
    input wire logic [15:0] switch_word_o, // Word
    input wire logic word_upd_o, // Refresh
    input wire logic [3:0] set_o // Setting
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_ok; set_wr_i && set_val_i <= 4'h8; endsequence
    sequence s_bad; set_wr_i && set_val_i > 4'h8; endsequence
    chk_reset_vals: assert property (disable iff (1'b0)
        !rst_b_i |=> set_o == 4'h4 && switch_word_o == 16'h0000)
        else $error("reset");
    chk_set_take: assert property (s_ok |=> set_o == $past(set_val_i))
        else $error("take");
    chk_set_refuse: assert property (s_bad |=> $stable(set_o))
        else $error("refuse");
    chk_set_range: assert property (set_o <= 4'h8)
        else $error("range");
    chk_set_cause: assert property ($changed(set_o) |-> $past(set_wr_i))
        else $error("cause");
    chk_word_upd: assert property ($changed(switch_word_o) |-> word_upd_o)
        else $error("upd");
    chk_upd_gap: assert property (word_upd_o |=> !word_upd_o [*8])
        else $error("gap");
endmodule
bind sid_top sid_properties i_chk (.clock_i, .rst_b_i, .set_wr_i,
    .set_val_i, .switch_word_o, .word_upd_o, .set_o);
`default_nettype wire

//--- sid_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module sid_switch_model (
    input wire logic clock_i, // Clock
    input wire logic [15:0] level_i, // Settled level
    input wire logic bounce_i, // Chatter on
    output var logic [15:0] pin_o = 16'h0000 // Contacts
);
    // Chatter flips every contact each cycle
    always @(posedge clock_i) pin_o <= bounce_i ? ~pin_o : level_i;
endmodule
`default_nettype wire

//--- sid_top.sv
// Contract
// - Sixteen switch inputs each give a debounced on or off bit to firmware.
// - Seven of the inputs are sensed back from the driver and output pins.
// - Every input is debounced so bounce shorter than the time is ignored.
// - Debounce time is the setting times 4 ms, from 0 up to 32 ms.
// - Without a written setting since reset the time is 16 ms.
// - All debounced states form one 16-bit word refreshed every 4 ms.
`timescale 1ns/1ps
`default_nettype none
module sid_top
    import sid_pkg::*;
#(
    parameter int NUM_INPUTS = sid_pkg::SID_NUM_INPUTS,
    parameter int CYC_PER_MS = sid_pkg::SID_CYC_PER_MS
) (
    input wire logic clock_i, // 100 MHz system clock
    input wire logic rst_b_i, // Sync reset, active low
    input wire logic [7:0] switch_pin_i, // Dedicated switch pins
    input wire logic [sid_pkg::SID_NUM_SENSE-1:0] output_sense_i, // Sense
    input wire logic unused_pin_i, // Spare position, sensed as input
    input wire logic set_wr_i, // Debounce setting write strobe
    input wire logic [sid_pkg::SID_SET_W-1:0] set_val_i, // Setting 0..8
    output logic [15:0] switch_word_o, // Debounced switch word
    output logic word_upd_o, // Pulse when the word refreshes
    output logic [sid_pkg::SID_SET_W-1:0] set_o // Active setting
);
    import sid_pkg::*;

    // Refuse widths and rates the fixed 16-bit word cannot serve
    if (NUM_INPUTS != SID_NUM_INPUTS || CYC_PER_MS < 1) begin : g_bad_param
        $error("sid_top: unsupported parameters");
    end

    logic [15:0] raw_all;
    logic [15:0] sync1_q, sync2_q;
    logic [15:0] deb;
    logic [31:0] div_q;
    logic tick_q;
    logic [1:0] word_cnt_q;
    logic [SID_SET_W-1:0] set_q;
    logic [15:0] word_q;
    logic upd_q;

    // Bits 0..7 switch pins, 8..14 sensed outputs, 15 spare position
    assign raw_all = {unused_pin_i, output_sense_i, switch_pin_i};

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
        end else begin
            sync1_q <= raw_all;
            sync2_q <= sync1_q;
        end
    end

    wire div_end = div_q == 32'(CYC_PER_MS - 1);
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            div_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_end ? 32'h00000000 : div_q + 32'h00000001;
            tick_q <= div_end;
        end
    end

    wire set_ok = set_val_i <= SID_SET_W'(SID_SET_MAX);
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            set_q <= SID_SET_DEFAULT;
        end else if (set_wr_i && set_ok) begin
            set_q <= set_val_i;
        end
    end

    // Setting times step gives the hold in millisecond ticks
    wire [SID_CNT_W-1:0] limit =
        SID_CNT_W'(set_q) * SID_CNT_W'(SID_STEP_MS);

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_filt
            sid_filter #(.CNT_W(SID_CNT_W)) u_filt (
                .clock_i(clock_i),
                .rst_b_i(rst_b_i),
                .tick_i(tick_q),
                .raw_i(sync2_q[g]),
                .limit_i(limit),
                .state_o(deb[g])
            );
        end
    endgenerate

    wire word_end = word_cnt_q == 2'(SID_WORD_MS - 1);
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            word_cnt_q <= 2'h0;
            word_q <= SID_WORD_RESET;
            upd_q <= 1'b0;
        end else begin
            upd_q <= 1'b0;
            if (tick_q) begin
                word_cnt_q <= word_end ? 2'h0 : word_cnt_q + 2'h1;
                if (word_end) begin
                    word_q <= deb;
                    upd_q <= 1'b1;
                end
            end
        end
    end

    assign switch_word_o = word_q;
    assign word_upd_o = upd_q;
    assign set_o = set_q;
endmodule
`default_nettype wire

//--- sid_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sid_top_tb;
    logic clock_i = 1'b0, rst_b_i = 1'b0, set_wr_i = 1'b0, bounce = 1'b0;
    logic [3:0] set_val_i = 4'h0, set_o;
    logic [15:0] level = 16'h0000, pins, word;
    logic upd;
    int miscompares = 0, cmp_count = 0;
    initial forever #5 clock_i = ~clock_i;
    sid_switch_model i_sw (.clock_i, .level_i(level), .bounce_i(bounce),
        .pin_o(pins));
    sid_top #(.CYC_PER_MS(4)) i_dut (.clock_i, .rst_b_i,
        .switch_pin_i(pins[7:0]), .output_sense_i(pins[14:8]),
        .unused_pin_i(pins[15]), .set_wr_i, .set_val_i,
        .switch_word_o(word), .word_upd_o(upd), .set_o);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] v, input logic [3:0] exp);
        @(posedge clock_i);
        set_wr_i <= 1'b1;
        set_val_i <= v;
        @(posedge clock_i);
        set_wr_i <= 1'b0;
        @(posedge clock_i);
        check({12'h000, set_o}, {12'h000, exp});
    endtask
    task automatic t_bounce;
        bounce <= 1'b1;
        repeat (20) @(posedge clock_i);
        bounce <= 1'b0;
        repeat (100) @(posedge clock_i);
        check(word, 16'h0000);
        level <= 16'hA5C3;
        repeat (55) @(posedge clock_i);
        check(word, 16'h0000);
        repeat (45) @(posedge clock_i);
        check(word, 16'hA5C3);
    endtask
    task automatic t_setting;
        wr(4'h9, 4'h4);
        wr(4'h8, 4'h8);
        wr(4'h0, 4'h0);
        level <= 16'h5A3C;
        repeat (40) @(posedge clock_i);
        check(word, 16'h5A3C);
    endtask
    task automatic t_refresh;
        int n;
        n = 0;
        while (upd !== 1'b1 && n < 40) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 40) miscompares++;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (upd !== 1'b1 && n < 40);
        check(16'(n), 16'h0010);
    endtask
    task automatic final_report;
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        check({12'h000, set_o}, 16'h0004);
        t_bounce;
        t_setting;
        t_refresh;
        final_report;
    end
endmodule
`default_nettype wire
